// file: logic/ppp_pkg.sv
/*
 * Constants for the parallel programming port: command codes, action
 * codes, fuse layout and defaults, memory geometry and timing counts.
 * Assumes a single system clock whose period is given below.
 */
package ppp_pkg;

    // Timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int ENTRY_GUARD_NS  = 100;
    localparam int ENTRY_GUARD_CYC = ((ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1)
                                   ? 1 : (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENTRY_TOGGLES   = 6;

    // Action select codes on a crystal-input strobe
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;

    // Command bytes
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h0080;
    localparam logic [7:0] CMD_WR_FUSE    = 8'h0040;
    localparam logic [7:0] CMD_WR_LOCK    = 8'h0020;
    localparam logic [7:0] CMD_WR_FLASH   = 8'h0010;
    localparam logic [7:0] CMD_WR_EEPROM  = 8'h0011;
    localparam logic [7:0] CMD_RD_SIG     = 8'h0008;
    localparam logic [7:0] CMD_RD_FUSE    = 8'h0004;
    localparam logic [7:0] CMD_RD_FLASH   = 8'h0002;
    localparam logic [7:0] CMD_RD_EEPROM  = 8'h0003;

    // Operations handed to the memory array
    localparam logic [1:0] OP_ERASE  = 2'h0;
    localparam logic [1:0] OP_FLASH  = 2'h1;
    localparam logic [1:0] OP_EEPROM = 2'h2;

    // Fuse layout: 0 means programmed
    localparam logic [7:0] FUSE_HIGH_RESET  = 8'h00FE;
    localparam logic [7:0] FUSE_LOW_RESET   = 8'h00CD;
    localparam int         FH_DEBUG_EN      = 1;
    localparam int         FH_BOUNDARY_EN   = 0;
    localparam int         FL_WATCHDOG_ON   = 7;
    localparam int         FL_EE_PRESERVE   = 6;
    localparam int         FL_BOOT_SIZE_HI  = 5;
    localparam int         FL_BOOT_SIZE_LO  = 4;
    localparam int         FL_RESET_VECTOR  = 3;
    localparam int         FL_STARTUP_HI    = 2;
    localparam int         FL_STARTUP_LO    = 1;
    localparam int         FL_CLOCK_SOURCE  = 0;
    localparam logic [7:0] LOCK_RESET       = 8'h00FF;
    localparam int         LOCK_FIRST       = 0;
    localparam logic [7:0] READ_FILL        = 8'h00FF;

    // Geometry
    localparam int FLASH_PAGES     = 320;
    localparam int FLASH_WORD_BITS = 6;
    localparam int FLASH_PAGE_MSB  = 14;
    localparam int EE_PAGES        = 128;
    localparam int EE_BYTE_BITS    = 2;
    localparam int EE_ADDR_MSB     = 8;

    // Signature space
    localparam logic [7:0] SIG_ADDR_0 = 8'h0000;
    localparam logic [7:0] SIG_ADDR_1 = 8'h0001;
    localparam logic [7:0] SIG_ADDR_2 = 8'h0002;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_GUARD  = 2'b01,
        MODE_PROG   = 2'b10
    } ppp_mode_e;

    typedef enum logic [1:0] {
        ST_READY    = 2'b00,
        ST_BUSY_NVM = 2'b01,
        ST_BUSY_LOC = 2'b10
    } ppp_busy_e;

endpackage

// file: logic/ppp_port.sv
/* Device-side parallel programming port: entry, loads, decode, fuses, locks, reads.
 * Assumes asynchronous programmer pins and an array controller on CLK_SYS that
 * answers each request with a one-cycle NVM_DONE. */
`timescale 1ns/1ps

// What this block does
// - Fuses read 0 when programmed and 1 when unprogrammed.
// - High fuse: debug enable bit 1 default 1, boundary enable bit 0 default 0.
// - Low fuse: watchdog 7, preserve 6, boot size 5:4, vector 3, start-up 2:1, clock 0.
// - Low defaults: boot size 00, start-up 10, the rest 1.
// - Clock select fuse unprogrammed selects the internal RC oscillator.
// - Chip erase leaves every fuse unchanged.
// - Fuse writes refused once the first lock bit is programmed.
// - Fuses latched at power-up and on mode entry; changes apply after exit.
// - The EEPROM preserve fuse acts at once when programmed.
// - Three identification bytes at signature 0 to 2, readable even when locked.
// - Fast RC calibration byte copied into its register during reset.
// - Flash: 320 pages of 64 words, word bits 5:0, page bits 14:6.
// - EEPROM: 128 pages of 4 bytes, byte bits 1:0, page bits 8:2.
// - Loaded command and address persist across operations.
// - Crystal strobe: 00 address, 01 data, 10 command, 11 nothing.
// - Write and output-enable strobes perform the loaded command.
// - Nine command bytes decoded for erase, writes and reads.
// - Ready/busy low while programming; data driven only with output enable low.
// - Entry aborted if an entry pin changes within 100 ns of high voltage.
module ppp_port #(
    parameter int         FUSE_PROG_CYCLES = 16,
    parameter logic [7:0] SIG_BYTE_0       = 8'h00A5,  // Arbitrary value
    parameter logic [7:0] SIG_BYTE_1       = 8'h005A,  // Arbitrary value
    parameter logic [7:0] SIG_BYTE_2       = 8'h003C,  // Arbitrary value
    parameter logic [7:0] RC_CAL_BYTE      = 8'h0080
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    input  wire logic [7:0]  DATA_IN,
    output logic      [7:0]  DATA_OUT,
    output logic             DATA_OE,
    input  wire logic        OE_N,
    input  wire logic        WR_N,
    input  wire logic        FIRST_BYTE_SELECT,
    input  wire logic        SECOND_BYTE_SELECT,
    input  wire logic        ACTION_SELECT_0,
    input  wire logic        ACTION_SELECT_1,
    input  wire logic        PAGE_LOAD_STROBE,
    input  wire logic        CRYSTAL_INPUT_STROBE,
    input  wire logic        RESET_PIN_LOW,
    input  wire logic        RESET_HIGH_VOLTAGE,
    output logic             READY_BUSY_OUT,
    output logic             PROG_MODE,
    output logic             NVM_REQ,
    output logic      [1:0]  NVM_OP,
    output logic             NVM_LATCH,
    output logic      [15:0] NVM_WDATA,
    output logic      [5:0]  WORD_IN_PAGE_INDEX,
    output logic      [8:0]  PAGE_INDEX,
    output logic      [8:0]  EEPROM_BYTE_ADDRESS,
    input  wire logic        NVM_DONE,
    input  wire logic [15:0] NVM_RDATA,
    output logic      [7:0]  FUSE_LOW_LATCHED,
    output logic      [7:0]  FUSE_HIGH_LATCHED,
    output logic             EEPROM_PRESERVE_FUSE,
    output logic             INTERNAL_RC_SELECT,
    output logic      [7:0]  LOCK_BITS,
    output logic      [7:0]  RC_CALIBRATION
);

    localparam int LCW = $clog2(FUSE_PROG_CYCLES + 1);
    logic [17:0]        sync1_q, sync2_q;
    logic [3:0]         prev_q;
    logic               hv_s, rstl_s, xt_s, pg_s, xa1_s, xa0_s, bs2_s, bs1_s;
    logic               wr_n_s, oe_n_s;
    logic [7:0]         din_s;
    logic               hv_rise, hv_fall, xt_rise, pg_rise, wr_fall;
    logic [3:0]         entry_pins;
    ppp_pkg::ppp_mode_e mode_q;
    ppp_pkg::ppp_busy_e busy_q;
    logic [2:0]         toggle_cnt_q;
    logic [3:0]         guard_cnt_q;
    logic [7:0]         cmd_q;
    logic [15:0]        addr_q;
    logic [7:0]         data_lo_q, data_hi_q;
    logic [7:0]         fuse_low_q, fuse_high_q;
    logic [7:0]         fuse_lat_low_q, fuse_lat_high_q;
    logic [7:0]         lock_q;
    logic [LCW-1:0]     loc_cnt_q;
    logic               erase_q, prog, wr_go, relatch, boot_q;
    logic [7:0]         data_out_d;

    // Pins are asynchronous to CLK_SYS
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= {RESET_HIGH_VOLTAGE, RESET_PIN_LOW, CRYSTAL_INPUT_STROBE,
                        PAGE_LOAD_STROBE, ACTION_SELECT_1, ACTION_SELECT_0,
                        SECOND_BYTE_SELECT, FIRST_BYTE_SELECT, WR_N, OE_N, DATA_IN};
            sync2_q <= sync1_q;
            prev_q  <= {hv_s, xt_s, pg_s, wr_n_s};
        end
    end

    assign {hv_s, rstl_s, xt_s, pg_s, xa1_s, xa0_s, bs2_s, bs1_s, wr_n_s, oe_n_s, din_s} = sync2_q;
    assign hv_rise    = hv_s && !prev_q[3];
    assign hv_fall    = !hv_s && prev_q[3];
    assign xt_rise    = xt_s && !prev_q[2];
    assign pg_rise    = pg_s && !prev_q[1];
    assign wr_fall    = !wr_n_s && prev_q[0];
    assign entry_pins = {pg_s, xa1_s, xa0_s, bs1_s};
    assign prog       = (mode_q == ppp_pkg::MODE_PROG);
    assign wr_go      = prog && wr_fall && (busy_q == ppp_pkg::ST_READY);
    // Programming-mode entry and exit
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_q       <= ppp_pkg::MODE_NORMAL;
            toggle_cnt_q <= '0;
            guard_cnt_q  <= '0;
        end else begin
            case (mode_q)
                ppp_pkg::MODE_NORMAL: begin
                    if (rstl_s && xt_rise && toggle_cnt_q < 3'(ppp_pkg::ENTRY_TOGGLES)) begin
                        toggle_cnt_q <= toggle_cnt_q + 3'h1;
                    end
                    if (hv_rise && toggle_cnt_q == 3'(ppp_pkg::ENTRY_TOGGLES)
                            && entry_pins == 4'h0) begin
                        mode_q      <= ppp_pkg::MODE_GUARD;
                        guard_cnt_q <= 4'(ppp_pkg::ENTRY_GUARD_CYC);
                    end
                end
                ppp_pkg::MODE_GUARD: begin
                    toggle_cnt_q <= '0;
                    guard_cnt_q  <= guard_cnt_q - 4'h1;
                    if (!hv_s || entry_pins != 4'h0) begin
                        mode_q <= ppp_pkg::MODE_NORMAL;
                    end else if (guard_cnt_q == 4'h1) begin
                        mode_q <= ppp_pkg::MODE_PROG;
                    end
                end
                ppp_pkg::MODE_PROG: begin
                    if (hv_fall) begin
                        mode_q <= ppp_pkg::MODE_NORMAL;
                    end
                end
                default: mode_q <= ppp_pkg::MODE_NORMAL;
            endcase
        end
    end
    // Command, address and data loads; all persist until reloaded
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            cmd_q     <= '0;
            addr_q    <= '0;
            data_lo_q <= '0;
            data_hi_q <= '0;
        end else if (prog && xt_rise) begin
            case ({xa1_s, xa0_s})
                ppp_pkg::ACT_ADDR: begin
                    if (bs1_s) addr_q[15:8] <= din_s;
                    else       addr_q[7:0]  <= din_s;
                end
                ppp_pkg::ACT_DATA: begin
                    if (bs1_s) data_hi_q <= din_s;
                    else       data_lo_q <= din_s;
                end
                ppp_pkg::ACT_CMD: cmd_q <= din_s;
                default: ;
            endcase
        end
    end
    // Latched copies reload at power-up, completed entry and exit; an aborted entry keeps them
    assign relatch = !boot_q || (prog && hv_fall) || (mode_q == ppp_pkg::MODE_GUARD
                   && guard_cnt_q == 4'h1 && hv_s && entry_pins == 4'h0);
    // Stored fuses; chip erase never touches them
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            fuse_low_q      <= ppp_pkg::FUSE_LOW_RESET;
            fuse_high_q     <= ppp_pkg::FUSE_HIGH_RESET;
            fuse_lat_low_q  <= ppp_pkg::FUSE_LOW_RESET;
            fuse_lat_high_q <= ppp_pkg::FUSE_HIGH_RESET;
            boot_q          <= 1'b0;
        end else begin
            boot_q <= 1'b1;
            if (wr_go && cmd_q == ppp_pkg::CMD_WR_FUSE && lock_q[ppp_pkg::LOCK_FIRST]) begin
                if (bs1_s) fuse_high_q <= {6'h3F,
                    data_lo_q[ppp_pkg::FH_DEBUG_EN:ppp_pkg::FH_BOUNDARY_EN]};
                else       fuse_low_q  <= data_lo_q;
            end
            if (relatch) begin
                fuse_lat_low_q  <= fuse_low_q;
                fuse_lat_high_q <= fuse_high_q;
            end
        end
    end
    // Lock bits only program toward 0; erase restores them when the array is clear
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            lock_q <= ppp_pkg::LOCK_RESET;
        end else if (busy_q == ppp_pkg::ST_BUSY_NVM && NVM_DONE && erase_q) begin
            lock_q <= ppp_pkg::LOCK_RESET;
        end else if (wr_go && cmd_q == ppp_pkg::CMD_WR_LOCK) begin
            lock_q <= lock_q & data_lo_q;
        end
    end

    // Busy sequencing and array requests
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_q    <= ppp_pkg::ST_READY;
            erase_q   <= 1'b0;
            loc_cnt_q <= '0;
            NVM_REQ   <= 1'b0;
            NVM_OP    <= ppp_pkg::OP_ERASE;
            NVM_LATCH <= 1'b0;
        end else begin
            NVM_REQ   <= 1'b0;
            NVM_LATCH <= prog && pg_rise;
            case (busy_q)
                ppp_pkg::ST_READY: begin
                    if (wr_go) begin
                        case (cmd_q)
                            ppp_pkg::CMD_CHIP_ERASE, ppp_pkg::CMD_WR_FLASH,
                            ppp_pkg::CMD_WR_EEPROM: begin
                                busy_q  <= ppp_pkg::ST_BUSY_NVM;
                                erase_q <= (cmd_q == ppp_pkg::CMD_CHIP_ERASE);
                                NVM_REQ <= 1'b1;
                                NVM_OP  <= (cmd_q == ppp_pkg::CMD_CHIP_ERASE) ? ppp_pkg::OP_ERASE
                                         : (cmd_q == ppp_pkg::CMD_WR_FLASH) ? ppp_pkg::OP_FLASH
                                         : ppp_pkg::OP_EEPROM;
                            end
                            ppp_pkg::CMD_WR_LOCK, ppp_pkg::CMD_WR_FUSE: begin
                                // Refused fuse write shows no busy period
                                if (cmd_q == ppp_pkg::CMD_WR_LOCK
                                        || lock_q[ppp_pkg::LOCK_FIRST]) begin
                                    busy_q    <= ppp_pkg::ST_BUSY_LOC;
                                    loc_cnt_q <= LCW'(FUSE_PROG_CYCLES);
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                ppp_pkg::ST_BUSY_NVM: begin
                    if (NVM_DONE) busy_q <= ppp_pkg::ST_READY;
                end
                ppp_pkg::ST_BUSY_LOC: begin
                    loc_cnt_q <= loc_cnt_q - LCW'(1);
                    if (loc_cnt_q == LCW'(1)) busy_q <= ppp_pkg::ST_READY;
                end
                default: busy_q <= ppp_pkg::ST_READY;
            endcase
        end
    end
    // Read multiplexer follows the loaded command
    always_comb begin
        data_out_d = ppp_pkg::READ_FILL;
        case (cmd_q)
            ppp_pkg::CMD_RD_FLASH:  data_out_d = bs1_s ? NVM_RDATA[15:8] : NVM_RDATA[7:0];
            ppp_pkg::CMD_RD_EEPROM: data_out_d = NVM_RDATA[7:0];
            ppp_pkg::CMD_RD_FUSE: begin
                case ({bs2_s, bs1_s})
                    2'b00:   data_out_d = fuse_low_q;
                    2'b11:   data_out_d = fuse_high_q;
                    2'b01:   data_out_d = lock_q;
                    default: data_out_d = ppp_pkg::READ_FILL;
                endcase
            end
            ppp_pkg::CMD_RD_SIG: begin
                // Lock bits deliberately not consulted
                if (bs1_s)                              data_out_d = RC_CAL_BYTE;
                else if (addr_q[7:0] == ppp_pkg::SIG_ADDR_0) data_out_d = SIG_BYTE_0;
                else if (addr_q[7:0] == ppp_pkg::SIG_ADDR_1) data_out_d = SIG_BYTE_1;
                else if (addr_q[7:0] == ppp_pkg::SIG_ADDR_2) data_out_d = SIG_BYTE_2;
                else                                    data_out_d = ppp_pkg::READ_FILL;
            end
            default: data_out_d = ppp_pkg::READ_FILL;
        endcase
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            DATA_OUT       <= '0;
            DATA_OE        <= 1'b0;
            RC_CALIBRATION <= RC_CAL_BYTE;
        end else begin
            DATA_OUT <= data_out_d;
            DATA_OE  <= prog && !oe_n_s;
        end
    end
    assign READY_BUSY_OUT       = (busy_q == ppp_pkg::ST_READY);
    assign PROG_MODE            = prog;
    assign NVM_WDATA            = {data_hi_q, data_lo_q};
    assign WORD_IN_PAGE_INDEX   = addr_q[ppp_pkg::FLASH_WORD_BITS-1:0];
    assign PAGE_INDEX           = addr_q[ppp_pkg::FLASH_PAGE_MSB:ppp_pkg::FLASH_WORD_BITS];
    assign EEPROM_BYTE_ADDRESS  = addr_q[ppp_pkg::EE_ADDR_MSB:0];
    assign FUSE_LOW_LATCHED     = fuse_lat_low_q;
    assign FUSE_HIGH_LATCHED    = fuse_lat_high_q;
    assign EEPROM_PRESERVE_FUSE = fuse_low_q[ppp_pkg::FL_EE_PRESERVE];
    assign INTERNAL_RC_SELECT   = fuse_lat_low_q[ppp_pkg::FL_CLOCK_SOURCE];
    assign LOCK_BITS            = lock_q;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    busy_on_write_a: assert property (wr_go && cmd_q == ppp_pkg::CMD_CHIP_ERASE
        |=> !READY_BUSY_OUT ##0 NVM_REQ) else $error("erase did not go busy");
    oe_release_a: assert property (oe_n_s |=> !DATA_OE)
        else $error("data bus driven with output enable high");
    fuse_lockout_a: assert property (wr_go && cmd_q == ppp_pkg::CMD_WR_FUSE
        && !lock_q[ppp_pkg::LOCK_FIRST] |=> $stable(fuse_low_q) && $stable(fuse_high_q)
        && READY_BUSY_OUT) else $error("fuse written while locked");
    erase_keeps_fuses_a: assert property (busy_q == ppp_pkg::ST_BUSY_NVM && erase_q
        |=> $stable(fuse_low_q) && $stable(fuse_high_q)) else $error("erase changed fuses");
    latch_hold_a: assert property (prog && $past(prog)
        |-> $stable(fuse_lat_low_q) && $stable(fuse_lat_high_q))
        else $error("latched fuses changed inside programming mode");
    preserve_now_a: assert property (wr_go && cmd_q == ppp_pkg::CMD_WR_FUSE && !bs1_s
        && lock_q[ppp_pkg::LOCK_FIRST]
        |=> EEPROM_PRESERVE_FUSE == $past(data_lo_q[ppp_pkg::FL_EE_PRESERVE]))
        else $error("preserve fuse not immediate");
    cmd_load_a: assert property (prog && xt_rise && {xa1_s, xa0_s} == ppp_pkg::ACT_CMD
        |=> cmd_q == $past(din_s)) else $error("command byte not loaded");
    cmd_kept_a: assert property (prog && wr_fall |=> $stable(cmd_q) [*2])
        else $error("command lost across operation");
    entry_abort_a: assert property (mode_q == ppp_pkg::MODE_GUARD
        && entry_pins != 4'h0 |=> mode_q == ppp_pkg::MODE_NORMAL)
        else $error("entry not aborted");
    sig_read_a: assert property (cmd_q == ppp_pkg::CMD_RD_SIG && !bs1_s
        && addr_q[7:0] == ppp_pkg::SIG_ADDR_0 |=> DATA_OUT == SIG_BYTE_0)
        else $error("signature byte wrong");

    enter_prog_c: cover property (mode_q == ppp_pkg::MODE_GUARD ##1 prog);
    erase_done_c: cover property (erase_q && busy_q == ppp_pkg::ST_BUSY_NVM && NVM_DONE);
    fuse_refused_c: cover property (wr_go && cmd_q == ppp_pkg::CMD_WR_FUSE
        && !lock_q[ppp_pkg::LOCK_FIRST]);
    page_latch_c: cover property (NVM_LATCH && cmd_q == ppp_pkg::CMD_WR_FLASH);

endmodule

// file: tb/ppp_array_model.sv
/* Array controller stand-in: answers each NVM_REQ with NVM_DONE after a
   fixed delay and shows a fixed read word. Assumes the port's clock and reset. */
`timescale 1ns/1ps
module ppp_array_model #(
    parameter int DELAY = 6
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    input  wire logic        NVM_REQ,
    output logic             NVM_DONE,
    output logic      [15:0] NVM_RDATA
);
    int cnt_q;
    assign NVM_RDATA = 16'hB469;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_q    <= 0;
            NVM_DONE <= 1'b0;
        end else begin
            NVM_DONE <= (cnt_q == 1);
            cnt_q    <= NVM_REQ ? DELAY : ((cnt_q != 0) ? cnt_q - 1 : 0);
        end
    end
endmodule

// file: tb/testbench.sv
/* Self-checking bench for the programming port: acts as the programmer.
   Assumes the array model answers flash, EEPROM and erase work. */
`timescale 1ns/1ps
module testbench;
    logic       clk_sys, reset_n, oe_n, wr_n, bs1, bs2, as0, as1, pgl, xtal;
    logic       rpl, hv, done, oe, rdy, prog, req, eep, rc, b, lat;
    logic [1:0] op;
    logic [5:0] wrd;
    logic [8:0] pg, eea;
    logic [7:0] din, dout, fl, fh, lk, cal;
    logic [15:0] rd_w, wdat;
    logic [7:0] cmds [3] = '{ppp_pkg::CMD_CHIP_ERASE, ppp_pkg::CMD_WR_FLASH,
                             ppp_pkg::CMD_WR_EEPROM};
    int         bad_count, checked;

    ppp_port #(.FUSE_PROG_CYCLES(4), .SIG_BYTE_0(8'h11), .SIG_BYTE_1(8'h22),
               .SIG_BYTE_2(8'h33), .RC_CAL_BYTE(8'h6B)) uut (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE(oe), .OE_N(oe_n), .WR_N(wr_n), .FIRST_BYTE_SELECT(bs1),
        .SECOND_BYTE_SELECT(bs2), .ACTION_SELECT_0(as0), .ACTION_SELECT_1(as1),
        .PAGE_LOAD_STROBE(pgl), .CRYSTAL_INPUT_STROBE(xtal), .RESET_PIN_LOW(rpl),
        .RESET_HIGH_VOLTAGE(hv), .READY_BUSY_OUT(rdy), .PROG_MODE(prog),
        .NVM_REQ(req), .NVM_OP(op), .NVM_LATCH(lat), .NVM_WDATA(wdat),
        .WORD_IN_PAGE_INDEX(wrd), .PAGE_INDEX(pg), .EEPROM_BYTE_ADDRESS(eea),
        .NVM_DONE(done), .NVM_RDATA(rd_w), .FUSE_LOW_LATCHED(fl),
        .FUSE_HIGH_LATCHED(fh), .EEPROM_PRESERVE_FUSE(eep),
        .INTERNAL_RC_SELECT(rc), .LOCK_BITS(lk), .RC_CALIBRATION(cal));
    ppp_array_model array (.CLK_SYS(clk_sys), .RESET_N(reset_n), .NVM_REQ(req),
        .NVM_DONE(done), .NVM_RDATA(rd_w));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Pulses held 3 cycles so the 2-flop sync sees them
    task automatic load(input logic [1:0] a, input logic b1, input logic [7:0] d);
        {as1, as0} <= a;
        bs1        <= b1;
        din        <= d;
        tick(3);
        xtal <= 1'b1;
        tick(3);
        xtal <= 1'b0;
        tick(3);
    endtask
    task automatic rd(input logic b2, input logic b1, input logic [7:0] exp);
        bs2  <= b2;
        bs1  <= b1;
        oe_n <= 1'b0;
        tick(5);
        chk(dout, exp);
        chk(oe, 1'b1);
        oe_n <= 1'b1;
        tick(5);
        chk(oe, 1'b0);
    endtask
    // Page-load pulse must give exactly one latch pulse carrying both data bytes
    task automatic latch_chk(input logic [7:0] hi, input logic [7:0] lo);
        int n;
        n = 0;
        pgl <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            tick(1);
            if (lat === 1'b1) n++;
        end
        pgl <= 1'b0;
        tick(3);
        chk(9'(n), 9'h001);
        chk(wdat[15:8], hi);
        chk(wdat[7:0], lo);
    endtask
    task automatic wr(output logic busy);
        wr_n <= 1'b0;
        busy = 1'b0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            if (i == 2) wr_n <= 1'b1;
            if (rdy === 1'b0) busy = 1'b1;
        end
        for (int i = 0; i < 300; i++) begin
            if (rdy === 1'b1) return;
            tick(1);
        end
        bad_count++;
        $display("ERROR at %0t: ready never returned", $time);
        report_and_stop;
    endtask
    task automatic enter(input logic bad);
        rpl <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            tick(3);
            xtal <= 1'b1;
            tick(3);
            xtal <= 1'b0;
        end
        tick(3);
        rpl <= 1'b0;
        hv  <= 1'b1;
        tick(1);
        pgl <= bad;
        tick(499);
        chk(prog, !bad);
        if (bad) begin
            hv  <= 1'b0;
            pgl <= 1'b0;
            tick(5);
        end
    endtask

    initial begin
        {reset_n, bs1, bs2, as0, as1, pgl, xtal, rpl, hv, din} = '0;
        {oe_n, wr_n} = 2'b11;
        bad_count = 0;
        checked = 0;
        tick(2);
        reset_n <= 1'b1;
        tick(2);
        chk(fl, 8'hCD);
        chk(fh, 8'hFE);
        chk(rc, 1'b1);
        chk(cal, 8'h6B);
        enter(1'b1);
        enter(1'b0);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSE);
        rd(1'b0, 1'b0, 8'hCD);
        rd(1'b1, 1'b1, 8'hFE);
        rd(1'b0, 1'b1, 8'hFF);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            load(ppp_pkg::ACT_ADDR, 1'b0, 8'(i));
            rd(1'b0, 1'b0, 8'(8'h11 * (i + 1)));
        end
        rd(1'b0, 1'b1, 8'h6B);
        load(2'h3, 1'b0, 8'h55);
        chk(eea, 9'h002);
        load(ppp_pkg::ACT_ADDR, 1'b1, 8'h4F);
        load(ppp_pkg::ACT_ADDR, 1'b0, 8'hC5);
        chk(wrd, 6'h05);
        chk(pg, 9'h13F);
        chk(eea, 9'h1C5);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FLASH);
        rd(1'b0, 1'b0, 8'h69);
        rd(1'b0, 1'b1, 8'hB4);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_EEPROM);
        rd(1'b0, 1'b1, 8'h69);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FLASH);
        load(ppp_pkg::ACT_DATA, 1'b0, 8'hA7);
        load(ppp_pkg::ACT_DATA, 1'b1, 8'h3C);
        latch_chk(8'h3C, 8'hA7);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_LOCK);
        load(ppp_pkg::ACT_DATA, 1'b0, 8'hFE);
        wr(b);
        chk(lk, 8'hFE);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FUSE);
        load(ppp_pkg::ACT_DATA, 1'b0, 8'hBF);
        wr(b);
        chk(b, 1'b0);
        chk(eep, 1'b1);
        for (int i = 0; i < 3; i++) begin
            load(ppp_pkg::ACT_CMD, 1'b0, cmds[i]);
            wr(b);
            chk(b, 1'b1);
            chk(op, 9'(i));
        end
        chk(lk, 8'hFF);
        chk(fl, 8'hCD);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FUSE);
        load(ppp_pkg::ACT_DATA, 1'b0, 8'hBF);
        wr(b);
        chk(b, 1'b1);
        chk(eep, 1'b0);
        chk(fl, 8'hCD);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSE);
        rd(1'b0, 1'b0, 8'hBF);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FUSE);
        load(ppp_pkg::ACT_DATA, 1'b0, 8'h01);
        bs1 <= 1'b1;
        wr(b);
        chk(b, 1'b1);
        load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSE);
        rd(1'b1, 1'b1, 8'hFD);
        hv <= 1'b0;
        tick(6);
        chk(fl, 8'hBF);
        chk(fh, 8'hFD);
        report_and_stop;
    end
endmodule
